// File: rtl/ibf_pkg.sv
// package: register map, field layout, reset values and types of the i2c flag block
// assumes: a 32-bit apb register bus, one word per register
package ibf_pkg;

    localparam int unsigned OWN_W        = 10;
    localparam int unsigned DATA_W       = 32;

    // register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;

    // control register fields
    localparam int unsigned CTRL_RUN     = 0;
    localparam int unsigned CTRL_MODE10  = 1;
    localparam int unsigned CTRL_COMPAT  = 2;
    localparam int unsigned CTRL_OWN_LSB = 16;

    // status register fields
    localparam int unsigned STAT_BUSY    = 0;
    localparam int unsigned STAT_MATCH   = 1;

    // reset values
    localparam logic             RST_RUN    = 1'h0;
    localparam logic             RST_MODE10 = 1'h0;
    localparam logic             RST_COMPAT = 1'h1;
    localparam logic [OWN_W-1:0] RST_OWN    = 10'h000;
    localparam logic             RST_FLAG   = 1'h0;

    // ten-bit address header pattern and last bit index of a byte
    localparam logic [4:0]  HDR10        = 5'h1E;
    localparam logic [2:0]  LAST_BIT     = 3'h7;

    typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_STAT} ibf_sel_e;

    typedef enum logic [2:0] {
        RX_IDLE, RX_ADDR1, RX_ACK1, RX_ADDR2, RX_ACK2, RX_DATA, RX_DACK, RX_SKIP
    } ibf_rx_e;

endpackage

// File: rtl/ibf_cond_if.sv
// interface: bus conditions seen on the two-wire bus, detector to flag logic
// assumes: all signals are one-cycle pulses on pclk except sda_bit
`timescale 1ns/1ns
interface ibf_cond_if;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda_bit;

    modport det  (output start, output stop, output scl_rise, output scl_fall, output sda_bit);
    modport cons (input start, input stop, input scl_rise, input scl_fall, input sda_bit);
endinterface

// File: rtl/ibf_cond_det.sv
// module: synchronises scl and sda and reports start, stop and clock edges
// assumes: pins are asynchronous to pclk; scl is far slower than pclk
`timescale 1ns/1ns
module ibf_cond_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic scl_pin,
    input wire logic sda_pin,
    ibf_cond_if.det  cond
);

    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic sda_m;
    logic sda_s;
    logic sda_q;
    logic next_scl_m;
    logic next_scl_s;
    logic next_scl_q;
    logic next_sda_m;
    logic next_sda_s;
    logic next_sda_q;

    // ----------------------------------------------------------------
    // two-stage synchronisers and previous sample
    // ----------------------------------------------------------------
    // the pipeline keeps running while disabled so no false edge appears at enable
    always_comb begin
        next_scl_m = ce ? scl_pin : scl_m;
        next_scl_s = ce ? scl_m   : scl_s;
        next_scl_q = ce ? scl_s   : scl_q;
        next_sda_m = ce ? sda_pin : sda_m;
        next_sda_s = ce ? sda_m   : sda_s;
        next_sda_q = ce ? sda_s   : sda_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_m <= 1'h1;
            scl_s <= 1'h1;
            scl_q <= 1'h1;
            sda_m <= 1'h1;
            sda_s <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_m <= next_scl_m;
            scl_s <= next_scl_s;
            scl_q <= next_scl_q;
            sda_m <= next_sda_m;
            sda_s <= next_sda_s;
            sda_q <= next_sda_q;
        end
    end

    // ----------------------------------------------------------------
    // conditions, blind while held in reset
    // ----------------------------------------------------------------
    assign cond.start    = ce & enable & scl_s & scl_q & sda_q & ~sda_s;
    assign cond.stop     = ce & enable & scl_s & scl_q & ~sda_q & sda_s;
    assign cond.scl_rise = ce & enable & scl_s & ~scl_q;
    assign cond.scl_fall = ce & enable & ~scl_s & scl_q;
    assign cond.sda_bit  = sda_s;

endmodule

// File: rtl/ibf_flags.sv
// module: i2c bus-busy and addressed-as-slave flags with an apb register file
// assumes: apb master on pclk; scl and sda arrive as open-drain pin levels
//
// Notes on behaviour
// - start sets busy flag, stop clears it
// - held in reset, no conditions; busy holds
// - after release busy holds until first condition
// - busy reads zero from power-up
// - own address match sets matched flag
// - standard mode: stop or other address clears
// - compat 7-bit: nack, stop, repeated start clear
// - compat 7-bit: other address keeps flag
// - compat 10-bit: nack, stop, other address clear
// - compat 10-bit: repeated start keeps flag
// - cleared flag ends slave acknowledging, except the 10-bit header acknowledge
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module ibf_flags #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              scl_pin,
    input  wire logic              sda_pin,
    output logic                   sda_out,
    output logic                   sda_oe
);

    if (ADDR_W < 3 || ADDR_W > 32) begin : g_chk
        $error("ibf_flags: ADDR_W must lie in 3..32");
    end

    localparam int unsigned OW = ibf_pkg::OWN_W;

    logic                 run;
    logic                 mode10;
    logic                 compat;
    logic [OW-1:0]        own;
    logic                 next_run;
    logic                 next_mode10;
    logic                 next_compat;
    logic [OW-1:0]        next_own;
    logic [31:0]          next_prdata;
    logic                 busy;
    logic                 match;
    logic                 next_busy;
    logic                 next_match;
    ibf_pkg::ibf_rx_e     state;
    ibf_pkg::ibf_rx_e     next_state;
    logic [2:0]           cnt;
    logic [2:0]           next_cnt;
    logic [6:0]           sh;
    logic [6:0]           next_sh;
    logic                 rw;
    logic                 next_rw;
    logic                 hit;
    logic                 next_hit;
    logic                 next_oe;
    logic                 set_m;
    logic                 clr_m;
    logic                 mismatch;
    logic                 nack;
    logic [7:0]           byte_v;
    logic                 acc;
    ibf_pkg::ibf_sel_e    sel;

    ibf_cond_if c ();

    ibf_cond_det ibf_cond_det_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .enable  (run),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin),
        .cond    (c.det)
    );

    // ----------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped offsets
    // ----------------------------------------------------------------
    function automatic ibf_pkg::ibf_sel_e reg_sel(input logic [ADDR_W-1:0] a);
        if (a == ADDR_W'(ibf_pkg::OFF_CTRL)) begin
            return ibf_pkg::SEL_CTRL;
        end else if (a == ADDR_W'(ibf_pkg::OFF_STATUS)) begin
            return ibf_pkg::SEL_STAT;
        end
        return ibf_pkg::SEL_NONE;
    endfunction

    assign sel     = reg_sel(paddr);
    assign acc     = psel & penable;
    assign pready  = 1'h1;
    assign pslverr = acc & (sel == ibf_pkg::SEL_NONE);
    assign sda_out = 1'h0;

    always_comb begin
        next_run    = run;
        next_mode10 = mode10;
        next_compat = compat;
        next_own    = own;
        next_prdata = prdata;
        if (ce && acc && pwrite && sel == ibf_pkg::SEL_CTRL) begin
            next_run    = pwdata[ibf_pkg::CTRL_RUN];
            next_mode10 = pwdata[ibf_pkg::CTRL_MODE10];
            next_compat = pwdata[ibf_pkg::CTRL_COMPAT];
            next_own    = pwdata[ibf_pkg::CTRL_OWN_LSB +: OW];
        end
        // status writes fall through untouched
        if (ce && psel && !penable && !pwrite) begin
            next_prdata = '0;
            unique case (sel)
                ibf_pkg::SEL_CTRL: begin
                    next_prdata[ibf_pkg::CTRL_RUN]             = run;
                    next_prdata[ibf_pkg::CTRL_MODE10]          = mode10;
                    next_prdata[ibf_pkg::CTRL_COMPAT]          = compat;
                    next_prdata[ibf_pkg::CTRL_OWN_LSB +: OW]   = own;
                end
                ibf_pkg::SEL_STAT: begin
                    next_prdata[ibf_pkg::STAT_BUSY]  = busy;
                    next_prdata[ibf_pkg::STAT_MATCH] = match;
                end
                ibf_pkg::SEL_NONE: begin
                    next_prdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run    <= ibf_pkg::RST_RUN;
            mode10 <= ibf_pkg::RST_MODE10;
            compat <= ibf_pkg::RST_COMPAT;
            own    <= ibf_pkg::RST_OWN;
            prdata <= '0;
        end else begin
            run    <= next_run;
            mode10 <= next_mode10;
            compat <= next_compat;
            own    <= next_own;
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // address receiver
    // ----------------------------------------------------------------
    assign byte_v = {sh, c.sda_bit};

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_sh    = sh;
        next_rw    = rw;
        next_hit   = hit;
        set_m      = 1'h0;
        mismatch   = 1'h0;
        nack       = 1'h0;
        if (c.stop) begin
            next_state = ibf_pkg::RX_IDLE;
        end else if (c.start) begin
            next_state = ibf_pkg::RX_ADDR1;
            next_cnt   = '0;
            next_hit   = 1'h0;
        end else if (c.scl_rise) begin
            next_sh  = byte_v[6:0];
            next_cnt = cnt + 3'h1;
            unique case (state)
                ibf_pkg::RX_IDLE, ibf_pkg::RX_SKIP: begin
                    next_cnt = '0;
                end
                ibf_pkg::RX_ADDR1: begin
                    if (cnt == ibf_pkg::LAST_BIT) begin
                        next_rw = byte_v[0];
                        if (mode10) begin
                            // header: high address bits; a read header needs a prior match
                            if (byte_v[7:3] == ibf_pkg::HDR10 && byte_v[2:1] == own[9:8]
                                && (!byte_v[0] || match)) begin
                                next_hit   = 1'h1;
                                next_state = ibf_pkg::RX_ACK1;
                            end else begin
                                mismatch   = 1'h1;
                                next_state = ibf_pkg::RX_SKIP;
                            end
                        end else if (byte_v[7:1] == own[6:0]) begin
                            set_m      = 1'h1;
                            next_hit   = 1'h1;
                            next_state = ibf_pkg::RX_ACK1;
                        end else begin
                            mismatch   = 1'h1;
                            next_state = ibf_pkg::RX_SKIP;
                        end
                    end
                end
                ibf_pkg::RX_ACK1: begin
                    next_cnt   = '0;
                    next_state = (mode10 && !rw) ? ibf_pkg::RX_ADDR2 : ibf_pkg::RX_DATA;
                end
                ibf_pkg::RX_ADDR2: begin
                    if (cnt == ibf_pkg::LAST_BIT) begin
                        if (byte_v == own[7:0]) begin
                            set_m      = 1'h1;
                            next_state = ibf_pkg::RX_ACK2;
                        end else begin
                            mismatch   = 1'h1;
                            next_state = ibf_pkg::RX_SKIP;
                        end
                    end
                end
                ibf_pkg::RX_ACK2: begin
                    next_cnt   = '0;
                    next_state = ibf_pkg::RX_DATA;
                end
                ibf_pkg::RX_DATA: begin
                    if (cnt == ibf_pkg::LAST_BIT) begin
                        next_state = ibf_pkg::RX_DACK;
                    end
                end
                ibf_pkg::RX_DACK: begin
                    next_cnt   = '0;
                    nack       = c.sda_bit;
                    next_state = c.sda_bit ? ibf_pkg::RX_SKIP : ibf_pkg::RX_DATA;
                end
            endcase
        end
    end

    // acknowledge slot opens at the falling edge after a byte, closes at the next
    always_comb begin
        next_oe = sda_oe;
        if (c.start || c.stop) begin
            next_oe = 1'h0;
        end else if (c.scl_fall) begin
            next_oe = (state == ibf_pkg::RX_ACK1 && hit)
                    | (state == ibf_pkg::RX_ACK2 && match)
                    | (state == ibf_pkg::RX_DACK && !rw && match);
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always_comb begin
        clr_m = c.stop
              | (c.start && busy && compat && !mode10)
              | (nack && compat)
              | (mismatch && (mode10 || !compat));
        next_match = set_m ? 1'h1 : (clr_m ? 1'h0 : match);
        next_busy  = c.start ? 1'h1 : (c.stop ? 1'h0 : busy);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= ibf_pkg::RX_IDLE;
            cnt    <= '0;
            sh     <= '0;
            rw     <= 1'h0;
            hit    <= 1'h0;
            sda_oe <= 1'h0;
            busy   <= ibf_pkg::RST_FLAG;
            match  <= ibf_pkg::RST_FLAG;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            sh     <= next_sh;
            rw     <= next_rw;
            hit    <= next_hit;
            sda_oe <= next_oe;
            busy   <= next_busy;
            match  <= next_match;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_busy_on_start:  assert property (c.start |=> busy)
        else $error("busy not set after start");
    a_busy_on_stop:   assert property (c.stop |=> !busy)
        else $error("busy not cleared after stop");
    a_busy_held_rst:  assert property (!run ##1 !run |-> $stable(busy))
        else $error("busy moved while held in reset");
    a_busy_until_ev:  assert property (!c.start && !c.stop |=> $stable(busy))
        else $error("busy moved without a condition");
    a_busy_zero_up:   assert property ($rose(presetn) |-> !busy)
        else $error("busy not zero after power-up");
    a_match_on_hit:   assert property (set_m |=> match && state inside
                                       {ibf_pkg::RX_ACK1, ibf_pkg::RX_ACK2})
        else $error("matched flag not set on own address");
    a_stop_clears:    assert property (c.stop |=> !match && state == ibf_pkg::RX_IDLE)
        else $error("stop did not clear matched flag");
    a_rstart_seven:   assert property (c.start && busy && compat && !mode10 |=> !match)
        else $error("repeated start kept flag in 7-bit mode");
    a_keep_mismatch:  assert property (mismatch && compat && !mode10 |=> $stable(match))
        else $error("other address cleared flag in 7-bit mode");
    a_mismatch_ten:   assert property (mismatch && mode10 |=> !match)
        else $error("other address kept flag in 10-bit mode");
    a_rstart_ten:     assert property (c.start && mode10 && match |=> match)
        else $error("repeated start cleared flag in 10-bit mode");
    a_no_ack_clear:   assert property (c.scl_fall && !match && state != ibf_pkg::RX_ACK1
                                       |=> !sda_oe)
        else $error("acknowledge driven while not addressed");
    a_status_ro:      assert property (acc && pwrite && sel == ibf_pkg::SEL_STAT
                                       && !c.start && !c.stop |=> $stable(busy))
        else $error("status write changed busy flag");

    c_seven_match:    cover property (set_m && !mode10);
    c_ten_match:      cover property (set_m && mode10);
    c_rstart_clear:   cover property (c.start && busy && match ##1 !match);
    c_nack_clear:     cover property (nack && match ##1 !match);

endmodule

// File: dv/ibf_i2c_master.sv
// partner model: an i2c master driving the two-wire bus, open drain
// assumes: sda_line is the wired data level with a pull-up; scl idles high
`timescale 1ns/1ns
module ibf_i2c_master (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    initial begin
        scl     = 1'h1;
        sda_drv = 1'h1;
    end

    // ------------------------------------------------------------
    // bus conditions and bytes, 160 ns clock period
    // ------------------------------------------------------------
    // puts pin changes 7 ns past a falling pclk edge so no change races a sample
    task automatic align();
        #((27 - ($time % 20)) % 20);
    endtask

    // start from idle, or repeated start from a low clock
    task automatic start_cond();
        align();
        sda_drv = 1'h1;
        #40 scl = 1'h1;
        #40 sda_drv = 1'h0;
        #40 scl = 1'h0;
        #40;
    endtask

    task automatic stop_cond();
        align();
        sda_drv = 1'h0;
        #40 scl = 1'h1;
        #40 sda_drv = 1'h1;
        #40;
    endtask

    // msb first, then the line is released for the acknowledge slot
    task automatic xfer_byte(input logic [7:0] b, output logic acked);
        align();
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            #40 scl = 1'h1;
            #80 scl = 1'h0;
            #40;
        end
        sda_drv = 1'h1;
        #40 scl = 1'h1;
        #40 acked = ~sda_line;
        #40 scl = 1'h0;
        #40;
    endtask
endmodule

// File: dv/i2c_bus_busy_and_slave_match_flags_tb.sv
// testbench: apb register access plus i2c master traffic against the flag block
// assumes: ibf_pkg and ibf_flags compiled; ibf_i2c_master is the bus partner
`timescale 1ns/1ns
module i2c_bus_busy_and_slave_match_flags_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl;
    logic        sda_drv;
    logic        sda_out;
    logic        sda_oe;
    wire         sda_line;
    logic        ack;
    logic        last_err;
    logic [31:0] rd;
    int          n_errors;
    int          n_tests;

    // wired level of the data line: pull-up, any party may pull low
    assign sda_line = sda_drv & ~sda_oe;

    always #10 pclk = ~pclk;

    ibf_flags #(.ADDR_W(8)) ibf_flags_inst (
        .pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_pin(scl), .sda_pin(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe)
    );

    ibf_i2c_master ibf_i2c_master_inst (
        .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 100) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 100) begin
            n_errors++;
        end
        r        = prdata;
        last_err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        apb(1'h1, a, d, dummy);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0, rd);
        check(what, e, rd);
    endtask

    task automatic stat(input logic [1:0] e);
        rd_chk("status", ibf_pkg::OFF_STATUS, {30'h0, e});
    endtask

    function automatic logic [31:0] ctrl(input logic run, input logic m10, input logic cpt,
                                         input logic [ibf_pkg::OWN_W-1:0] own);
        logic [31:0] w;
        w = 32'h0;
        w[ibf_pkg::CTRL_RUN] = run;
        w[ibf_pkg::CTRL_MODE10] = m10;
        w[ibf_pkg::CTRL_COMPAT] = cpt;
        w[ibf_pkg::CTRL_OWN_LSB +: ibf_pkg::OWN_W] = own;
        return w;
    endfunction

    task automatic send(input logic [7:0] b, input logic exp_ack);
        ibf_i2c_master_inst.xfer_byte(b, ack);
        check("ack", {31'h0, exp_ack}, {31'h0, ack});
    endtask

    task automatic sta();
        ibf_i2c_master_inst.start_cond();
    endtask

    task automatic sto();
        ibf_i2c_master_inst.stop_cond();
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #400000;
        n_errors++;
        $display("watchdog expired");
        results();
    end

    initial begin
        pclk     = 1'h0;
        presetn  = 1'h0;
        psel     = 1'h0;
        penable  = 1'h0;
        pwrite   = 1'h0;
        paddr    = 8'h00;
        pwdata   = 32'h0;
        n_errors = 0;
        n_tests  = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rd_chk("ctrl", ibf_pkg::OFF_CTRL, ctrl(1'h0, 1'h0, 1'h1, 10'h000));
        stat(2'h0);
        wr(ibf_pkg::OFF_STATUS, 32'h3);
        stat(2'h0);
        rd_chk("unmapped", 8'h08, 32'h0);
        check("slverr", 32'h1, {31'h0, last_err});
        sta();
        stat(2'h0);
        sto();
        $display("test reset_values done");
        wr(ibf_pkg::OFF_CTRL, ctrl(1'h1, 1'h0, 1'h1, 10'h02A));
        // host waits out the longest transfer before trusting the flag
        repeat (300) @(posedge pclk);
        stat(2'h0);
        sta();
        stat(2'h1);
        send(8'h54, 1'h1);
        check("sda_out", 32'h0, {31'h0, sda_out});
        stat(2'h3);
        send(8'h55, 1'h1);
        sta();
        stat(2'h1);
        send(8'h26, 1'h0);
        sto();
        stat(2'h0);
        sta();
        send(8'h55, 1'h1);
        send(8'hFF, 1'h0);
        stat(2'h1);
        sto();
        sta();
        send(8'h54, 1'h1);
        sto();
        stat(2'h0);
        $display("test compat_7bit done");
        wr(ibf_pkg::OFF_CTRL, ctrl(1'h1, 1'h0, 1'h0, 10'h02A));
        sta();
        send(8'h54, 1'h1);
        sta();
        stat(2'h3);
        send(8'h26, 1'h0);
        stat(2'h1);
        send(8'h00, 1'h0);
        sto();
        // compat mode switched on mid-address so a foreign address meets a set flag
        sta();
        send(8'h54, 1'h1);
        sta();
        fork
            send(8'h26, 1'h0);
            begin
                repeat (20) @(posedge pclk);
                wr(ibf_pkg::OFF_CTRL, ctrl(1'h1, 1'h0, 1'h1, 10'h02A));
            end
        join
        stat(2'h3);
        sto();
        $display("test standard_mode done");
        wr(ibf_pkg::OFF_CTRL, ctrl(1'h1, 1'h1, 1'h1, 10'h2A5));
        sta();
        send(8'hF4, 1'h1);
        send(8'hA5, 1'h1);
        stat(2'h3);
        sta();
        stat(2'h3);
        send(8'hF5, 1'h1);
        send(8'hFF, 1'h0);
        stat(2'h1);
        sto();
        sta();
        send(8'hF4, 1'h1);
        send(8'hA5, 1'h1);
        sta();
        send(8'hF4, 1'h1);
        send(8'h00, 1'h0);
        stat(2'h1);
        sto();
        stat(2'h0);
        $display("test compat_10bit done");
        wr(ibf_pkg::OFF_CTRL, ctrl(1'h1, 1'h0, 1'h1, 10'h02A));
        sta();
        wr(ibf_pkg::OFF_CTRL, ctrl(1'h0, 1'h0, 1'h1, 10'h02A));
        sto();
        stat(2'h1);
        wr(ibf_pkg::OFF_CTRL, ctrl(1'h1, 1'h0, 1'h1, 10'h02A));
        stat(2'h1);
        sta();
        sto();
        repeat (300) @(posedge pclk);
        stat(2'h0);
        $display("test held_in_reset done");
        results();
    end
endmodule
